// *** design/omap_access_port.sv ***
// on-chip memory access port: start pointer, streaming windows, unlock, commit page
`include "omap_params.svh"

// How it works
// - low start pointer byte is read/write, resets to zero
// - first eeprom window read in a transaction returns byte at start pointer
// - later eeprom window reads in that transaction step the address by one
// - after first window access the register address stays fixed on that window
// - transaction end releases the window lock; auto-increment resumes next time
// - first sram window read returns the sram byte at the start pointer
// - first sram window write stores the byte at the start pointer
// - later sram window accesses step the address and act on the next byte
// - rom window is read-only, starts at pointer, steps on each further read
// - program start only triggers when the previous transaction wrote the key
// - commit page field picks which of eight pages gets the register commit
// - 10-bit crystal load code reads back, bits 9:8 high, byte low
// - upper pointer holds bits 11:8; eeprom/sram use nine bits, rom twelve
// - commit request copies registers into chosen sram page, then self-clears
// - while busy during program cycle of about 230 ms, eeprom access denied
module omap_access_port #(
  parameter int unsigned PROG_CYCLES = `OMAP_PROG_TIME_MS * `OMAP_CLK_KHZ
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port from the i2c front end
  input wire logic txn_end,
  input wire logic reg_addr_load,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_stb,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_req,
  output logic req_ready,
  // read data stream
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  // neighbouring control register
  input wire logic program_start_bit,
  input wire logic reg_to_sram_copy_bit,
  output logic eeprom_busy_flag,
  output logic commit_busy,
  // register image source for commit
  output logic [5:0] commit_src_addr,
  input wire logic [7:0] commit_src_data,
  // crystal load capacitance code
  input wire logic [9:0] xtal_load_cap_code
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] sram [0:`OMAP_NVM_DEPTH-1];
  logic [7:0] eeprom [0:`OMAP_NVM_DEPTH-1];

  logic [7:0] mem_start_addr_low;
  logic [3:0] mem_start_addr_high;
  logic [7:0] program_unlock_key;
  logic [3:0] commit_page_field;
  logic [7:0] reg_ptr;
  logic win_lock;
  omap_pkg::omap_addr_t mem_ptr;
  logic key_seen;
  logic prog_armed;
  omap_pkg::omap_eng_e eng;
  logic [31:0] eng_cnt;
  logic [8:0] copy_idx;
  logic [2:0] commit_page;
  logic [7:0] buf0;
  logic [7:0] buf1;
  logic buf1_valid;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  omap_pkg::omap_addr_t mem_start_pointer;
  omap_pkg::omap_addr_t eff_addr;
  logic at_ee;
  logic at_sram;
  logic at_rom;
  logic is_win;
  logic ee_deny;
  logic rd_acc;
  logic win_step;
  logic sram_wr;
  logic prog_go;
  logic commit_go;
  logic pop;
  logic [7:0] rd_byte;

  // pointer halves and window hits; ee/sram take nine bits, rom twelve
  assign mem_start_pointer = {mem_start_addr_high, mem_start_addr_low};
  assign at_ee = (reg_ptr == `OMAP_ADDR_EE_WIN);
  assign at_sram = (reg_ptr == `OMAP_ADDR_SRAM_WIN);
  assign at_rom = (reg_ptr == `OMAP_ADDR_ROM_WIN);
  assign is_win = at_ee | at_sram | at_rom;
  assign ee_deny = at_ee & eeprom_busy_flag;
  assign rd_acc = reg_rd_req & req_ready;
  // first access uses the start pointer, later ones the private copy plus one
  assign eff_addr = win_lock ? omap_pkg::omap_addr_t'(mem_ptr + 12'h001) : mem_start_pointer;
  // writes to read-only windows are dropped and do not step the stream
  assign win_step = is_win & ~ee_deny & (rd_acc | (reg_wr_stb & at_sram));
  // the sram port is owned by the engine while a commit runs
  assign sram_wr = reg_wr_stb & at_sram & (eng != omap_pkg::OMAP_ENG_COMMIT);
  assign prog_go = program_start_bit & prog_armed & (eng == omap_pkg::OMAP_ENG_IDLE);
  assign commit_go = reg_to_sram_copy_bit & ~program_start_bit
                     & (eng == omap_pkg::OMAP_ENG_IDLE);
  assign pop = rd_valid & rd_ready;

  // rom contents are a fixed table computed from the address
  function automatic logic [7:0] rom_byte(input omap_pkg::omap_addr_t a);
    rom_byte = a[7:0] ^ {a[11:8], a[11:8]};
  endfunction : rom_byte

  // read mux; a denied eeprom read returns zero
  always_comb begin
    rd_byte = `OMAP_RESET_BYTE;
    case (reg_ptr)
      `OMAP_ADDR_START_LO: rd_byte = mem_start_addr_low;
      `OMAP_ADDR_START_HI: rd_byte = {4'h0, mem_start_addr_high};
      `OMAP_ADDR_EE_WIN: rd_byte = ee_deny ? `OMAP_RESET_BYTE
                                   : eeprom[eff_addr[`OMAP_NVM_AW-1:0]];
      `OMAP_ADDR_SRAM_WIN: rd_byte = sram[eff_addr[`OMAP_NVM_AW-1:0]];
      `OMAP_ADDR_ROM_WIN: rd_byte = rom_byte(eff_addr);
      `OMAP_ADDR_UNLOCK: rd_byte = program_unlock_key;
      `OMAP_ADDR_PAGE: rd_byte = {4'h0, commit_page_field};
      `OMAP_ADDR_XCAP_HI: rd_byte = {6'h00, xtal_load_cap_code[9:8]};
      `OMAP_ADDR_XCAP_LO: rd_byte = xtal_load_cap_code[7:0];
      default: rd_byte = `OMAP_RESET_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // start pointer, unlock key and page field
  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_start_addr_low <= `OMAP_RESET_BYTE;
      mem_start_addr_high <= `OMAP_RESET_NIB;
      program_unlock_key <= `OMAP_RESET_BYTE;
      commit_page_field <= `OMAP_RESET_NIB;
    end else if (reg_wr_stb) begin
      case (reg_ptr)
        `OMAP_ADDR_START_LO: mem_start_addr_low <= reg_wdata;
        `OMAP_ADDR_START_HI: mem_start_addr_high <= reg_wdata[3:0];
        `OMAP_ADDR_UNLOCK: program_unlock_key <= reg_wdata;
        `OMAP_ADDR_PAGE: commit_page_field <= reg_wdata[3:0]; // reserved bits dropped
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register address pointer and stream lock
  // ----------------------------------------------------------------
  // the start pointer is never touched here, only the private copy
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_ptr <= `OMAP_RESET_BYTE;
      win_lock <= 1'b0;
      mem_ptr <= '0;
    end else if (reg_addr_load) begin
      reg_ptr <= reg_addr_in;
      win_lock <= 1'b0;
    end else if (txn_end) begin
      win_lock <= 1'b0;
    end else if (win_step) begin
      win_lock <= 1'b1;
      mem_ptr <= eff_addr;
    end else if ((reg_wr_stb | rd_acc) & ~is_win) begin
      reg_ptr <= reg_ptr + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // unlock tracking
  // ----------------------------------------------------------------
  // a transaction qualifies if it wrote the key; only the next one may program
  always_ff @(posedge mclk) begin
    if (rst) begin
      key_seen <= 1'b0;
      prog_armed <= 1'b0;
    end else begin
      if (txn_end) begin
        key_seen <= 1'b0;
        prog_armed <= key_seen;
      end else if (reg_wr_stb & (reg_ptr == `OMAP_ADDR_UNLOCK)) begin
        key_seen <= (reg_wdata == `OMAP_UNLOCK_CODE);
      end
      if (prog_go) begin
        prog_armed <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // program and commit engine
  // ----------------------------------------------------------------
  // program copies sram into eeprom, then holds busy until the full cycle time, copy included, is up
  always_ff @(posedge mclk) begin
    if (rst) begin
      eng <= omap_pkg::OMAP_ENG_IDLE;
      eng_cnt <= 32'h0000_0000;
      copy_idx <= '0;
      commit_page <= 3'h0;
      commit_src_addr <= '0;
      eeprom_busy_flag <= 1'b0;
      commit_busy <= 1'b0;
    end else begin
      case (eng)
        omap_pkg::OMAP_ENG_IDLE: begin
          eng_cnt <= 32'h0000_0000;
          copy_idx <= '0;
          commit_src_addr <= '0;
          if (prog_go) begin
            eng <= omap_pkg::OMAP_ENG_COPY;
            eeprom_busy_flag <= 1'b1;
          end else if (commit_go) begin
            eng <= omap_pkg::OMAP_ENG_COMMIT;
            commit_page <= commit_page_field[2:0];
            commit_busy <= 1'b1;
          end
        end
        omap_pkg::OMAP_ENG_COPY: begin
          eng_cnt <= eng_cnt + 32'h0000_0001;
          copy_idx <= copy_idx + 9'h001;
          if (copy_idx == `OMAP_NVM_LAST) begin
            eng <= omap_pkg::OMAP_ENG_WAIT;
          end
        end
        omap_pkg::OMAP_ENG_WAIT: begin
          eng_cnt <= eng_cnt + 32'h0000_0001;
          if (eng_cnt >= PROG_CYCLES - 1) begin
            eng <= omap_pkg::OMAP_ENG_IDLE;
            eeprom_busy_flag <= 1'b0;
          end
        end
        omap_pkg::OMAP_ENG_COMMIT: begin
          commit_src_addr <= commit_src_addr + 6'h01;
          if (commit_src_addr == `OMAP_PAGE_LAST) begin
            eng <= omap_pkg::OMAP_ENG_IDLE;
            commit_busy <= 1'b0;
          end
        end
        default: eng <= omap_pkg::OMAP_ENG_IDLE;
      endcase
    end
  end

  // eeprom array write port, used only by the program copy
  always_ff @(posedge mclk) begin
    if (eng == omap_pkg::OMAP_ENG_COPY) begin
      eeprom[copy_idx] <= sram[copy_idx];
    end
  end

  // sram write port: commit has priority, host writes are shut out meanwhile
  always_ff @(posedge mclk) begin
    if (eng == omap_pkg::OMAP_ENG_COMMIT) begin
      sram[{commit_page, commit_src_addr}] <= commit_src_data;
    end else if (sram_wr & win_step) begin
      sram[eff_addr[`OMAP_NVM_AW-1:0]] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // two-entry read buffer
  // ----------------------------------------------------------------
  // req_ready drops when both entries are full, so a stalled reader loses nothing
  always_ff @(posedge mclk) begin
    if (rst) begin
      buf0 <= `OMAP_RESET_BYTE;
      buf1 <= `OMAP_RESET_BYTE;
      rd_valid <= 1'b0;
      buf1_valid <= 1'b0;
      req_ready <= 1'b1;
    end else begin
      if (pop) begin
        if (buf1_valid) begin
          buf0 <= buf1;
          buf1_valid <= 1'b0;
          req_ready <= 1'b1;
        end else if (rd_acc) begin
          buf0 <= rd_byte;
        end else begin
          rd_valid <= 1'b0;
        end
      end else if (rd_acc) begin
        if (!rd_valid) begin
          buf0 <= rd_byte;
          rd_valid <= 1'b1;
        end else begin
          buf1 <= rd_byte;
          buf1_valid <= 1'b1;
          req_ready <= 1'b0;
        end
      end
    end
  end
  assign rd_data = buf0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_lock_first;
    win_step & ~win_lock & ~reg_addr_load & ~txn_end |=> win_lock && mem_ptr == $past(mem_start_pointer);
  endproperty
  a_lock_first: assert property (p_lock_first) else $error("first window access off start");

  property p_step_one;
    win_step & win_lock & ~reg_addr_load & ~txn_end |=> mem_ptr == $past(mem_ptr) + 12'h001;
  endproperty
  a_step_one: assert property (p_step_one) else $error("stream pointer did not step by one");

  property p_ptr_fixed;
    win_lock & ~reg_addr_load |=> reg_ptr == $past(reg_ptr);
  endproperty
  a_ptr_fixed: assert property (p_ptr_fixed) else $error("register address moved while locked");

  property p_end_unlock;
    txn_end |=> !win_lock;
  endproperty
  a_end_unlock: assert property (p_end_unlock) else $error("lock survived transaction end");

  property p_no_prog;
    program_start_bit & ~prog_armed & ~eeprom_busy_flag & ~commit_busy |=> !eeprom_busy_flag;
  endproperty
  a_no_prog: assert property (p_no_prog) else $error("program started without unlock");

  // helper count of busy cycles; a 64-fold repeat would be unrolled by the tools
  logic [6:0] commit_len_cnt;
  always_ff @(posedge mclk) begin
    if (rst | ~commit_busy) commit_len_cnt <= 7'h00;
    else commit_len_cnt <= commit_len_cnt + 7'h01;
  end

  property p_commit_len;
    $fell(commit_busy) || (commit_len_cnt == 7'h40) |-> !commit_busy && commit_len_cnt == 7'h40;
  endproperty
  a_commit_len: assert property (p_commit_len) else $error("commit did not last 64 cycles");

  property p_busy_hold;
    $rose(eeprom_busy_flag) |-> eeprom_busy_flag [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy flag dropped early");

  property p_start_kept;
    win_step & ~reg_wr_stb |=> mem_start_pointer == $past(mem_start_pointer);
  endproperty
  a_start_kept: assert property (p_start_kept) else $error("start pointer changed by stream");

  property p_xcap;
    rd_acc & ~rd_valid & (reg_ptr == `OMAP_ADDR_XCAP_HI) |=> rd_valid && rd_data[7:2] == 6'h00;
  endproperty
  a_xcap: assert property (p_xcap) else $error("load cap high byte has upper bits");

  property p_low_write;
    reg_wr_stb & (reg_ptr == `OMAP_ADDR_START_LO) |=> mem_start_addr_low == $past(reg_wdata);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low start byte not written");

endmodule : omap_access_port

// *** design/omap_params.svh ***
// offsets, field widths, reset values and timing counts of the memory access port
`ifndef OMAP_PARAMS_SVH
`define OMAP_PARAMS_SVH

// register offsets on the device register port
`define OMAP_ADDR_START_LO 8'h8c
`define OMAP_ADDR_START_HI 8'h8b
`define OMAP_ADDR_EE_WIN 8'h8d
`define OMAP_ADDR_SRAM_WIN 8'h8e
`define OMAP_ADDR_ROM_WIN 8'h8f
`define OMAP_ADDR_UNLOCK 8'h90
`define OMAP_ADDR_PAGE 8'h91
`define OMAP_ADDR_XCAP_HI 8'hc7
`define OMAP_ADDR_XCAP_LO 8'hc8

// values, reset values and field widths
`define OMAP_UNLOCK_CODE 8'hea
`define OMAP_RESET_BYTE 8'h00
`define OMAP_RESET_NIB 4'h0
`define OMAP_NVM_AW 9
`define OMAP_ROM_AW 12
`define OMAP_NVM_DEPTH 512
`define OMAP_NVM_LAST 9'h1ff
`define OMAP_PAGE_AW 6
`define OMAP_PAGE_LAST 6'h3f

// timing: erase/program cycle length and clock rate
`define OMAP_PROG_TIME_MS 230
`define OMAP_CLK_KHZ 200000

`endif

// *** design/omap_pkg.sv ***
// types shared by the on-chip memory access port
package omap_pkg;
  // engine states, gray along idle-copy-wait; commit sits next to idle
  typedef enum logic [1:0] {
    OMAP_ENG_IDLE = 2'b00,
    OMAP_ENG_COPY = 2'b01,
    OMAP_ENG_WAIT = 2'b11,
    OMAP_ENG_COMMIT = 2'b10
  } omap_eng_e;
  typedef logic [11:0] omap_addr_t;
endpackage : omap_pkg

// *** testbench/omap_access_port_tb_top.sv ***
// self-checking bench for the on-chip memory access port
module omap_access_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 600;

  logic mclk, rst, txn_end, reg_addr_load, reg_wr_stb, reg_rd_req, req_ready;
  logic [7:0] reg_addr_in, reg_wdata, rd_data, commit_src_data;
  logic rd_valid, rd_ready, program_start_bit, reg_to_sram_copy_bit;
  logic eeprom_busy_flag, commit_busy;
  logic [5:0] commit_src_addr;
  logic [9:0] xtal_load_cap_code;
  int mismatches = 0;
  int num_checks = 0;
  int n;

  // ----------------------------------------
  // clock, neighbours and instances
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // register image seen by the commit engine, a simple function of the index
  assign commit_src_data = {2'b00, commit_src_addr} ^ 8'h5a;

  omap_access_port #(.PROG_CYCLES(PROG)) i_omap_access_port (.mclk(mclk), .rst(rst),
    .txn_end(txn_end), .reg_addr_load(reg_addr_load), .reg_addr_in(reg_addr_in),
    .reg_wr_stb(reg_wr_stb), .reg_wdata(reg_wdata), .reg_rd_req(reg_rd_req),
    .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .program_start_bit(program_start_bit), .reg_to_sram_copy_bit(reg_to_sram_copy_bit),
    .eeprom_busy_flag(eeprom_busy_flag), .commit_busy(commit_busy),
    .commit_src_addr(commit_src_addr), .commit_src_data(commit_src_data),
    .xtal_load_cap_code(xtal_load_cap_code));

  omap_host i_omap_host (.mclk(mclk), .txn_end(txn_end), .reg_addr_load(reg_addr_load),
    .reg_addr_in(reg_addr_in), .reg_wr_stb(reg_wr_stb), .reg_wdata(reg_wdata),
    .reg_rd_req(reg_rd_req), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready));

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  function automatic logic [7:0] rom(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction : rom

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // a head byte that never shows ends the run
  task automatic takechk(input string what, input logic [7:0] exp);
    logic [7:0] d;
    bit ok;
    i_omap_host.take(d, ok);
    if (!ok) begin
      mismatches++;
      $display("wrong value %s expected %h seen nothing", what, exp);
      end_of_test();
    end else begin
      check(what, exp, d);
    end
  endtask : takechk

  // one read request, then its answer
  task automatic rdchk(input string what, input logic [7:0] exp);
    i_omap_host.req();
    takechk(what, exp);
  endtask : rdchk

  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask : pulse

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    rd_ready = 1'b1;
    program_start_bit = 1'b0;
    reg_to_sram_copy_bit = 1'b0;
    xtal_load_cap_code = 10'h2a5;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    // reset values; plain registers auto-increment
    i_omap_host.load(8'h8c);
    rdchk("start_low", 8'h00);
    i_omap_host.stop();
    i_omap_host.load(8'h90);
    rdchk("unlock_key", 8'h00);
    rdchk("commit_page", 8'h00);
    i_omap_host.stop();
    i_omap_host.load(8'h8b);
    i_omap_host.wr(8'h01);
    i_omap_host.wr(8'h23);
    i_omap_host.stop();
    i_omap_host.load(8'h8b);
    rdchk("start_high", 8'h01);
    rdchk("start_low", 8'h23);
    i_omap_host.stop();
    $display("test registers done");
    // rom streams on twelve bits, lock holds, a write is ignored
    i_omap_host.load(8'h8f);
    rdchk("rom_window", rom(12'h123));
    rdchk("rom_window", rom(12'h124));
    i_omap_host.wr(8'h77);
    rdchk("rom_window", rom(12'h125));
    i_omap_host.stop();
    i_omap_host.load(8'h8c);
    rdchk("start_low", 8'h23);
    i_omap_host.stop();
    i_omap_host.load(8'h8f);
    rdchk("rom_window", rom(12'h123));
    i_omap_host.stop();
    $display("test rom done");
    // sram written then read back through the window
    i_omap_host.load(8'h8e);
    i_omap_host.wr(8'ha1);
    i_omap_host.wr(8'hb2);
    i_omap_host.wr(8'hc3);
    i_omap_host.stop();
    i_omap_host.load(8'h8e);
    rdchk("sram_window", 8'ha1);
    rdchk("sram_window", 8'hb2);
    rdchk("sram_window", 8'hc3);
    i_omap_host.stop();
    $display("test sram done");
    // key followed by another transaction must not arm the program cycle
    i_omap_host.load(8'h90);
    i_omap_host.wr(8'hea);
    i_omap_host.stop();
    i_omap_host.load(8'h91);
    i_omap_host.wr(8'h02);
    i_omap_host.stop();
    pulse(program_start_bit);
    repeat (3) @(negedge mclk);
    check("busy_flag", 8'h00, {7'h00, eeprom_busy_flag});
    i_omap_host.load(8'h90);
    i_omap_host.wr(8'hea);
    i_omap_host.stop();
    pulse(program_start_bit);
    check("busy_flag", 8'h01, {7'h00, eeprom_busy_flag});
    i_omap_host.load(8'h8d);
    rdchk("eeprom_busy_read", 8'h00);
    i_omap_host.stop();
    for (n = 0; n < PROG + 50 && eeprom_busy_flag !== 1'b0; n++) @(negedge mclk);
    check("busy_flag", 8'h00, {7'h00, eeprom_busy_flag});
    if (eeprom_busy_flag !== 1'b0) begin
      end_of_test();
    end
    i_omap_host.load(8'h8d);
    rdchk("eeprom_window", 8'ha1);
    rdchk("eeprom_window", 8'hb2);
    rdchk("eeprom_window", 8'hc3);
    i_omap_host.stop();
    $display("test program done");
    // commit into page 2 takes 64 cycles, then read the page back
    pulse(reg_to_sram_copy_bit);
    for (n = 0; n < 100 && commit_busy === 1'b1; n++) @(negedge mclk);
    check("commit_cycles", 8'd64, n[7:0]);
    if (commit_busy !== 1'b0) begin
      end_of_test();
    end
    i_omap_host.load(8'h8b);
    i_omap_host.wr(8'h00);
    i_omap_host.wr(8'h85);
    i_omap_host.stop();
    i_omap_host.load(8'h8e);
    rdchk("commit_image", 8'h05 ^ 8'h5a);
    rdchk("commit_image", 8'h06 ^ 8'h5a);
    i_omap_host.stop();
    $display("test commit done");
    // crystal code readback is read-only
    i_omap_host.load(8'hc7);
    i_omap_host.wr(8'hff);
    i_omap_host.stop();
    i_omap_host.load(8'hc7);
    rdchk("xtal_high", 8'h02);
    rdchk("xtal_low", 8'ha5);
    i_omap_host.stop();
    xtal_load_cap_code = 10'h15a;
    i_omap_host.load(8'hc7);
    rdchk("xtal_high", 8'h01);
    rdchk("xtal_low", 8'h5a);
    i_omap_host.stop();
    $display("test xtal done");
    // reader stalls: two entries fill the buffer, a third request is refused
    rd_ready = 1'b0;
    i_omap_host.load(8'h8f);
    i_omap_host.req();
    i_omap_host.req();
    @(negedge mclk);
    check("req_ready", 8'h00, {7'h00, req_ready});
    i_omap_host.req();
    rd_ready = 1'b1;
    takechk("rom_head", rom(12'h085));
    takechk("rom_next", rom(12'h086));
    rdchk("rom_after_refusal", rom(12'h087));
    i_omap_host.stop();
    $display("test buffer done");
    end_of_test();
  end
endmodule : omap_access_port_tb_top

// *** testbench/omap_host.sv ***
// host model that drives the register port of the memory access port
module omap_host (
  // clock
  input wire logic mclk,
  // register port towards the device
  output logic txn_end,
  output logic reg_addr_load,
  output logic [7:0] reg_addr_in,
  output logic reg_wr_stb,
  output logic [7:0] reg_wdata,
  output logic reg_rd_req,
  // read stream from the device
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // idle levels and bus cycles
  // ----------------------------------------
  // all changes at the falling edge, held across exactly one rising edge
  initial begin
    txn_end = 1'b0;
    reg_addr_load = 1'b0;
    reg_addr_in = 8'h00;
    reg_wr_stb = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_req = 1'b0;
  end

  // stale address and data are inverted so the device cannot lean on them
  task automatic load(input logic [7:0] a);
    @(negedge mclk);
    reg_addr_load = 1'b1;
    reg_addr_in = a;
    @(negedge mclk);
    reg_addr_load = 1'b0;
    reg_addr_in = ~a;
  endtask : load

  task automatic wr(input logic [7:0] d);
    @(negedge mclk);
    reg_wr_stb = 1'b1;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr_stb = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  // stop or repeated start closes the transaction
  task automatic stop();
    @(negedge mclk);
    txn_end = 1'b1;
    @(negedge mclk);
    txn_end = 1'b0;
  endtask : stop

  // one read request; the caller decides whether it should be refused
  task automatic req();
    @(negedge mclk);
    reg_rd_req = 1'b1;
    @(negedge mclk);
    reg_rd_req = 1'b0;
  endtask : req

  // collect the head byte, then let its pop edge pass
  task automatic take(output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    for (int n = 0; n < 40 && !ok; n++) begin
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
        d = rd_data;
        ok = 1'b1;
      end
      @(negedge mclk);
    end
  endtask : take
endmodule : omap_host
